// ==== rtl/power_link_if.sv ====
// Inductive link between receiver and transmitter, reduced to its digital meaning.
// Assumes both ends share core_clk_i; packets use valid/ready.
`timescale 1ns/1ps
`default_nettype none
interface power_link_if;
    import rx_power_pkg::*;
    logic ping;
    logic contract;
    logic pkt_valid;
    logic pkt_ready;
    pkt_kind_type pkt_kind;
    logic [7:0] pkt_data;

    modport rx_end (input ping, input contract, input pkt_ready,
                    output pkt_valid, output pkt_kind, output pkt_data);
    modport tx_end (output ping, output contract, output pkt_ready,
                    input pkt_valid, input pkt_kind, input pkt_data);
endinterface : power_link_if
`default_nettype wire

// ==== rtl/rx_power_cfg.svh ====
// Constants of the wireless power receiver control block and its transmitter end.
// Assumes a single 125 MHz core clock; voltages and currents arrive as digital mV / mA codes.
`ifndef RX_POWER_CFG_SVH
`define RX_POWER_CFG_SVH

`define CLK_HZ 125000000
`define CYC_PER_MS (`CLK_HZ / 1000)

`define CE_FAST_MS 30
`define CE_SLOW_MS 250
`define CONV_MS 150
`define CE_FAST_CYC (`CE_FAST_MS * `CYC_PER_MS)
`define CE_SLOW_CYC (`CE_SLOW_MS * `CYC_PER_MS)
`define CONV_CYC (`CONV_MS * `CYC_PER_MS)
`define PING_GAP_MS 500
`define PING_GAP_CYC (`PING_GAP_MS * `CYC_PER_MS)

`define PING_MEM_MV 16'h0640
`define CTRL_HIGH_MV 16'h0578
`define CTRL_LOW_MV 16'h0064
`define HOT_DEFAULT_MV 16'h00C8
`define STARTUP_TGT_MV 16'h1F40
`define TGT_LIGHT_MV 16'h1B58
`define TGT_MID_MV 16'h1770
`define TGT_HEAVY_MV 16'h1388
`define OVP_DEFAULT_MV 16'h2EE0
`define BAND_MV 16'h00C8
`define TX_START_MV 16'h1388

`define EPT_UNKNOWN 8'h00
`define EPT_CHARGED 8'h01
`define EPT_FAULT 8'h02
`define EPT_OVERTEMP 8'h03
`define EPT_OVERVOLT 8'h04
`define CE_MAX_DOWN 8'h80
`define SIG_STRENGTH 8'hC0
`define CFG_BYTE 8'h05
`define ID_BYTE 8'h5A

`endif

// ==== rtl/rx_power_ctrl.sv ====
// Receiver end: startup handshake, control error loop, end-power-transfer and presence detect.
// Assumes analog levels arrive as synchronous mV/mA codes and the link is power_link_if.
`timescale 1ns/1ps
`default_nettype none
`include "rx_power_cfg.svh"
module rx_power_ctrl #(
    parameter int unsigned CE_FAST_CYC = `CE_FAST_CYC,
    parameter int unsigned CE_SLOW_CYC = `CE_SLOW_CYC,
    parameter int unsigned CONV_CYC = `CONV_CYC,
    parameter logic [15:0] HOT_MV = `HOT_DEFAULT_MV,
    parameter logic [15:0] OVP_MV = `OVP_DEFAULT_MV,
    parameter bit HOST_PORT = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    power_link_if.rx_end link,
    input wire logic [15:0] vrect_mv_i,
    input wire logic [15:0] iout_ma_i,
    input wire logic [15:0] ilim_ma_i,
    input wire logic [15:0] thermal_control_mv_i,
    input wire logic [15:0] ping_memory_mv_i,
    input wire logic adapter_present_i,
    input wire logic fault_i,
    input wire logic host_align_i,
    output logic output_en_o,
    output logic ldo_en_o,
    output logic presence_detect_n_o,
    output logic presence_detect_n_oe_o,
    output logic [7:0] ept_code_o
);
    import rx_power_pkg::*;

    // ==========================================================
    // Helpers
    // Returns {hit, reason}; priority fault, heat, charge, adapter
    function automatic logic [8:0] ept_check(input logic [15:0] ctrl, input logic adapter,
                                             input logic fault);
        logic [8:0] r;
        r = 9'h000;
        if (fault) begin
            r = {1'b1, `EPT_FAULT};
        end else if (ctrl < `CTRL_LOW_MV || ctrl < HOT_MV) begin
            r = {1'b1, `EPT_OVERTEMP};
        end else if (ctrl > `CTRL_HIGH_MV) begin
            r = {1'b1, `EPT_CHARGED};
        end else if (adapter) begin
            r = {1'b1, `EPT_UNKNOWN};
        end
        return r;
    endfunction : ept_check

    // Error code: difference scaled by 32 mV a step, clamped to a signed byte
    function automatic logic [7:0] ce_code(input logic signed [16:0] err);
        logic signed [16:0] s;
        s = err >>> 5;
        if (s > 17'sd127) begin
            return 8'h7F;
        end else if (s < -17'sd128) begin
            return 8'h80;
        end
        return s[7:0];
    endfunction : ce_code

    // ==========================================================
    // Presence detect
    logic pd_q;
    logic pd_d;

    always_comb begin
        pd_d = ping_memory_mv_i > `PING_MEM_MV;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= pd_d;
        end
    end

    assign presence_detect_n_o = 1'b0;
    assign presence_detect_n_oe_o = pd_q;

    // ==========================================================
    // Main sequence
    rx_state_type state_q, state_d;
    logic pkt_valid_q, pkt_valid_d;
    pkt_kind_type pkt_kind_q, pkt_kind_d;
    logic [7:0] pkt_data_q, pkt_data_d;
    logic [7:0] ept_q, ept_d;
    logic [31:0] ce_cnt_q, ce_cnt_d;
    logic [31:0] conv_cnt_q, conv_cnt_d;
    logic [15:0] target_q, target_d;
    logic out_en_q, out_en_d;
    logic ldo_q, ldo_d;

    logic [8:0] ept_now;
    logic signed [16:0] err;
    logic in_band;
    logic rising;
    logic over_v;
    logic busy;

    always_comb begin
        ept_now = ept_check(thermal_control_mv_i, adapter_present_i, fault_i);
        // Load share picks the target; heavier load runs a lower rectifier voltage
        if ({1'b0, iout_ma_i, 3'h0} + {3'h0, iout_ma_i, 1'b0} < {4'h0, ilim_ma_i}) begin
            target_d = `TGT_LIGHT_MV;
        end else if ({iout_ma_i, 1'b0} < {1'b0, ilim_ma_i}) begin
            target_d = `TGT_MID_MV;
        end else begin
            target_d = `TGT_HEAVY_MV;
        end
        if (state_q != RX_ACTIVE) begin
            target_d = `STARTUP_TGT_MV;
        end
        err = $signed({1'b0, target_q}) - $signed({1'b0, vrect_mv_i});
        in_band = (err <= $signed({1'b0, `BAND_MV})) && (err >= -$signed({1'b0, `BAND_MV}));
        rising = err < -$signed({1'b0, `BAND_MV});
        over_v = vrect_mv_i > OVP_MV;
        // One idle cycle between packets gives the far end time to step its state
        busy = pkt_valid_q;
    end

    always_comb begin
        state_d = state_q;
        pkt_valid_d = pkt_valid_q && !link.pkt_ready;
        pkt_kind_d = pkt_kind_q;
        pkt_data_d = pkt_data_q;
        ept_d = ept_q;
        ce_cnt_d = (ce_cnt_q != 32'h0) ? ce_cnt_q - 32'h1 : ce_cnt_q;
        conv_cnt_d = conv_cnt_q;
        out_en_d = 1'b0;
        ldo_d = !over_v;
        unique case (state_q)
            RX_IDLE: begin
                if (link.ping) begin
                    if (ept_now[8]) begin
                        ept_d = ept_now[7:0];
                        state_d = RX_END;
                    end else begin
                        state_d = RX_STRENGTH;
                    end
                end
            end
            RX_STRENGTH: begin
                if (!busy) begin
                    pkt_valid_d = 1'b1;
                    pkt_kind_d = PKT_STRENGTH;
                    pkt_data_d = `SIG_STRENGTH;
                    state_d = RX_CONFIG;
                end
            end
            RX_CONFIG: begin
                if (!busy) begin
                    pkt_valid_d = 1'b1;
                    pkt_kind_d = PKT_CONFIG;
                    pkt_data_d = `CFG_BYTE;
                    state_d = RX_IDENT;
                end
            end
            RX_IDENT: begin
                if (!busy) begin
                    pkt_valid_d = 1'b1;
                    pkt_kind_d = PKT_IDENT;
                    pkt_data_d = `ID_BYTE;
                    state_d = RX_WAIT;
                end
            end
            RX_WAIT: begin
                ce_cnt_d = 32'h0;
                conv_cnt_d = 32'h0;
                if (ept_now[8]) begin
                    ept_d = ept_now[7:0];
                    state_d = RX_END;
                end else if (link.contract) begin
                    state_d = RX_RAMP;
                end
            end
            RX_RAMP, RX_ACTIVE: begin
                // Output stays off until contract plus startup target reached
                out_en_d = (state_q == RX_ACTIVE) && !over_v;
                if (in_band || target_d != target_q) begin
                    conv_cnt_d = 32'h0;
                end else begin
                    conv_cnt_d = conv_cnt_q + 32'h1;
                end
                if (state_q == RX_RAMP && in_band) begin
                    state_d = RX_ACTIVE;
                end
                if (ept_now[8]) begin
                    ept_d = ept_now[7:0];
                    state_d = RX_END;
                    out_en_d = 1'b0;
                end else if (conv_cnt_q >= CONV_CYC - 1) begin
                    ept_d = `EPT_OVERVOLT;
                    state_d = RX_END;
                    out_en_d = 1'b0;
                // Only the first overvoltage cycle jumps the queue; later ones keep the cadence
                end else if (!busy && (ce_cnt_q == 32'h0 || (over_v && ldo_q))) begin
                    pkt_valid_d = 1'b1;
                    pkt_kind_d = PKT_CTRL_ERR;
                    if (over_v) begin
                        pkt_data_d = `CE_MAX_DOWN;
                    end else if (HOST_PORT && host_align_i) begin
                        pkt_data_d = 8'h00;
                    end else begin
                        pkt_data_d = ce_code(err);
                    end
                    // Fast cadence while the rectifier sits above the target band
                    ce_cnt_d = (rising || over_v) ? CE_FAST_CYC - 1 : CE_SLOW_CYC - 1;
                end
            end
            RX_END: begin
                if (!busy) begin
                    pkt_valid_d = 1'b1;
                    pkt_kind_d = PKT_END;
                    pkt_data_d = ept_q;
                    state_d = RX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= RX_IDLE;
            pkt_valid_q <= 1'b0;
            pkt_kind_q <= PKT_STRENGTH;
            pkt_data_q <= 8'h00;
            ept_q <= 8'h00;
            ce_cnt_q <= 32'h0;
            conv_cnt_q <= 32'h0;
            target_q <= `STARTUP_TGT_MV;
            out_en_q <= 1'b0;
            ldo_q <= 1'b1;
        end else begin
            state_q <= state_d;
            pkt_valid_q <= pkt_valid_d;
            pkt_kind_q <= pkt_kind_d;
            pkt_data_q <= pkt_data_d;
            ept_q <= ept_d;
            ce_cnt_q <= ce_cnt_d;
            conv_cnt_q <= conv_cnt_d;
            target_q <= target_d;
            out_en_q <= out_en_d;
            ldo_q <= ldo_d;
        end
    end

    assign link.pkt_valid = pkt_valid_q;
    assign link.pkt_kind = pkt_kind_q;
    assign link.pkt_data = pkt_data_q;
    assign output_en_o = out_en_q;
    assign ldo_en_o = ldo_q;
    assign ept_code_o = ept_q;

endmodule : rx_power_ctrl
`default_nettype wire

// ==== rtl/rx_power_pkg.sv ====
// Types shared by both ends of the wireless power link.
// Assumes rx_power_cfg.svh holds all figures.
package rx_power_pkg;

    typedef enum logic [2:0] {
        PKT_STRENGTH = 3'h0,
        PKT_CONFIG = 3'h1,
        PKT_IDENT = 3'h2,
        PKT_CTRL_ERR = 3'h3,
        PKT_END = 3'h4
    } pkt_kind_type;

    // Gray codes along ping, opening packets, contract, ramp, loop, end
    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_STRENGTH = 3'h1,
        RX_CONFIG = 3'h3,
        RX_IDENT = 3'h2,
        RX_WAIT = 3'h6,
        RX_RAMP = 3'h7,
        RX_ACTIVE = 3'h5,
        RX_END = 3'h4
    } rx_state_type;

    typedef enum logic [2:0] {
        TX_ANALOG = 3'h0,
        TX_PING = 3'h1,
        TX_COLLECT = 3'h3,
        TX_POWER = 3'h2,
        TX_LOW = 3'h6
    } tx_state_type;

endpackage : rx_power_pkg

// ==== rtl/tx_power_ctrl.sv ====
// Transmitter end: digital ping, opening packet check, contract, setpoint from error packets.
// Assumes object detection comes from its own analog ping as a synchronous level.
`timescale 1ns/1ps
`default_nettype none
`include "rx_power_cfg.svh"
module tx_power_ctrl #(
    parameter int unsigned PING_GAP_CYC = `PING_GAP_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    power_link_if.tx_end link,
    input wire logic object_detect_i,
    output logic power_on_o,
    output logic low_power_o,
    output logic [15:0] vrect_set_mv_o,
    output logic [7:0] end_reason_o
);
    import rx_power_pkg::*;

    tx_state_type state_q, state_d;
    logic [1:0] seen_q, seen_d;
    logic [15:0] set_q, set_d;
    logic [7:0] reason_q, reason_d;
    logic [31:0] gap_q, gap_d;
    logic ping_q, ping_d;
    logic take;

    assign link.pkt_ready = 1'b1;
    assign take = link.pkt_valid;

    always_comb begin
        state_d = state_q;
        seen_d = seen_q;
        set_d = set_q;
        reason_d = reason_q;
        gap_d = (gap_q != 32'h0) ? gap_q - 32'h1 : gap_q;
        ping_d = 1'b0;
        unique case (state_q)
            TX_ANALOG: begin
                seen_d = 2'h0;
                set_d = `TX_START_MV;
                if (object_detect_i) begin
                    state_d = TX_PING;
                end
            end
            TX_PING: begin
                ping_d = 1'b1;
                state_d = TX_COLLECT;
            end
            TX_COLLECT: begin
                if (take) begin
                    if (link.pkt_kind == PKT_END) begin
                        reason_d = link.pkt_data;
                        gap_d = PING_GAP_CYC - 1;
                        state_d = TX_LOW;
                    end else if (link.pkt_kind == pkt_kind_type'({1'b0, seen_q})) begin
                        seen_d = seen_q + 2'h1;
                        if (seen_q == 2'h2) begin
                            state_d = TX_POWER;
                        end
                    end else begin
                        state_d = TX_ANALOG;
                    end
                end
            end
            TX_POWER: begin
                // Slow loop: setpoint walks per packet, no timeout applied
                if (take && link.pkt_kind == PKT_CTRL_ERR) begin
                    set_d = set_q + {{4{link.pkt_data[7]}}, link.pkt_data, 4'h0};
                end else if (take && link.pkt_kind == PKT_END) begin
                    reason_d = link.pkt_data;
                    gap_d = PING_GAP_CYC - 1;
                    state_d = TX_LOW;
                end
                if (!object_detect_i) begin
                    state_d = TX_ANALOG;
                end
            end
            TX_LOW: begin
                seen_d = 2'h0;
                set_d = `TX_START_MV;
                if (!object_detect_i) begin
                    state_d = TX_ANALOG;
                end else if (gap_q == 32'h0) begin
                    state_d = TX_PING;
                end
            end
            default: begin
                state_d = TX_ANALOG;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= TX_ANALOG;
            seen_q <= 2'h0;
            set_q <= `TX_START_MV;
            reason_q <= 8'h00;
            gap_q <= 32'h0;
            ping_q <= 1'b0;
        end else begin
            state_q <= state_d;
            seen_q <= seen_d;
            set_q <= set_d;
            reason_q <= reason_d;
            gap_q <= gap_d;
            ping_q <= ping_d;
        end
    end

    assign link.ping = ping_q;
    assign link.contract = (state_q == TX_POWER);
    assign power_on_o = (state_q == TX_POWER) || (state_q == TX_COLLECT);
    assign low_power_o = (state_q == TX_LOW);
    assign vrect_set_mv_o = set_q;
    assign end_reason_o = reason_q;

endmodule : tx_power_ctrl
`default_nettype wire

// ==== testbench/rx_power_monitor.sv ====
// Assertions on the packet link between the receiver and transmitter ends.
// Assumes both ends share core_clk_i and the active-high asynchronous rst_i.
`timescale 1ns/1ps
`default_nettype none
module rx_power_monitor (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ping,
    input wire logic contract,
    input wire logic pkt_valid,
    input wire logic pkt_ready,
    input wire rx_power_pkg::pkt_kind_type pkt_kind,
    input wire logic [7:0] pkt_data
);
    import rx_power_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] ident_q;
    logic [2:0] ident_d;
    // ==========================================================
    // Identification packets of the last three cycles
    always_comb begin
        ident_d = {ident_q[1:0], pkt_valid & pkt_ready & (pkt_kind == PKT_IDENT)};
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ident_q <= 3'h0;
        end else begin
            ident_q <= ident_d;
        end
    end
    // ==========================================================
    // Link properties
    sequence s_strength; pkt_valid && pkt_kind == PKT_STRENGTH; endsequence
    sequence s_config; pkt_valid && pkt_kind == PKT_CONFIG; endsequence
    sequence s_ident; pkt_valid && pkt_kind == PKT_IDENT; endsequence
    sequence s_end; pkt_valid && pkt_kind == PKT_END; endsequence
    property p_ping_pulse; ping |=> !ping; endproperty
    property p_ping_answer;
        ping |-> ##[1:4] pkt_valid && (pkt_kind == PKT_STRENGTH || pkt_kind == PKT_END);
    endproperty
    property p_open_order; s_strength |-> ##[2:3] s_config ##[2:3] s_ident; endproperty
    property p_grant; s_ident |-> ##[1:3] contract; endproperty
    property p_grant_cause; $rose(contract) |-> ident_q != 3'h0; endproperty
    property p_single; pkt_valid |=> !pkt_valid; endproperty
    property p_ramp;
        $rose(contract) |-> ##[0:6] pkt_valid && (pkt_kind == PKT_CTRL_ERR || pkt_kind == PKT_END);
    endproperty
    property p_end_drop; pkt_valid && pkt_kind == PKT_END && contract |-> ##[1:3] !contract;
    endproperty
    property p_end_quiet; s_end |=> !pkt_valid [*3]; endproperty
    property p_end_code; s_end |-> pkt_data <= 8'h04; endproperty
    a_ping_pulse: assert property (p_ping_pulse)
        else $error("ping longer than one cycle");
    a_ping_answer: assert property (p_ping_answer)
        else $error("no answer to ping");
    a_open_order: assert property (p_open_order)
        else $error("opening packets out of order");
    a_grant: assert property (p_grant)
        else $error("no contract after identification");
    a_grant_cause: assert property (p_grant_cause)
        else $error("contract without identification");
    a_single: assert property (p_single)
        else $error("packet valid held");
    a_ramp: assert property (p_ramp)
        else $error("no ramp request after contract");
    a_end_drop: assert property (p_end_drop)
        else $error("contract kept after end packet");
    a_end_quiet: assert property (p_end_quiet)
        else $error("packet right after end packet");
    a_end_code: assert property (p_end_code)
        else $error("end reason out of range");
endmodule : rx_power_monitor
`default_nettype wire

// ==== testbench/testbench.sv ====
// Bench joining receiver and transmitter ends through one link.
// Assumes 125 MHz clock and shortened periods; the rectifier follows the setpoint unless held.
`timescale 1ns/1ps
`default_nettype none
`include "rx_power_cfg.svh"
module testbench;
    import rx_power_pkg::*;
    localparam int FAST = 20;
    localparam int SLOW = 100;
    localparam int CONV = 400;
    localparam int GAP = 200;
    logic core_clk_i, rst_i, adapter, fault, align, detect, hold_en;
    logic [15:0] vrect = 16'h1388;
    logic [15:0] iout, ilim, therm, pmem, hold_mv, vset;
    logic out_en, ldo_en, pd_n, pd_oe, power_on, low_power;
    logic [7:0] ept_code, end_reason, d;
    pkt_kind_type k;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;
    // Pull-up on the open-drain presence pin
    wire logic pd_wire = pd_oe ? pd_n : 1'b1;
    power_link_if link_a();
    rx_power_ctrl #(.CE_FAST_CYC(FAST), .CE_SLOW_CYC(SLOW), .CONV_CYC(CONV)) rx_power_ctrl_i (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .link(link_a.rx_end), .vrect_mv_i(vrect),
        .iout_ma_i(iout), .ilim_ma_i(ilim), .thermal_control_mv_i(therm),
        .ping_memory_mv_i(pmem), .adapter_present_i(adapter), .fault_i(fault),
        .host_align_i(align), .output_en_o(out_en), .ldo_en_o(ldo_en),
        .presence_detect_n_o(pd_n), .presence_detect_n_oe_o(pd_oe), .ept_code_o(ept_code));
    tx_power_ctrl #(.PING_GAP_CYC(GAP)) tx_power_ctrl_i (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .link(link_a.tx_end), .object_detect_i(detect),
        .power_on_o(power_on), .low_power_o(low_power), .vrect_set_mv_o(vset),
        .end_reason_o(end_reason));
    rx_power_monitor rx_power_monitor_i (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .ping(link_a.ping), .contract(link_a.contract),
        .pkt_valid(link_a.pkt_valid), .pkt_ready(link_a.pkt_ready),
        .pkt_kind(link_a.pkt_kind), .pkt_data(link_a.pkt_data));
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    // Plant model: no real coil, so the rectifier tracks the setpoint unless hold_en forces hold_mv
    always @(posedge core_clk_i) begin
        vrect <= hold_en ? hold_mv : vset;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            results();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    function automatic logic in_band(input logic [15:0] v, input logic [15:0] t);
        return v + `BAND_MV >= t && v <= t + `BAND_MV;
    endfunction : in_band
    task automatic next_pkt(input int lim, output logic [7:0] data, output int waited);
        waited = 0;
        do begin
            @(posedge core_clk_i);
            waited++;
        end while (link_a.pkt_valid !== 1'b1 && waited < lim);
        check("packet", link_a.pkt_valid, 1'b1);
        k = link_a.pkt_kind;
        data = link_a.pkt_data;
    endtask : next_pkt
    task automatic wait_end(input int lim);
        k = PKT_CTRL_ERR;
        for (int j = 0; j < 50 && k !== PKT_END; j++) begin
            next_pkt(lim, d, n);
        end
    endtask : wait_end
    task automatic bring_up(input int lim, output logic [7:0] first_ce);
        pkt_kind_type order[3];
        order = '{PKT_STRENGTH, PKT_CONFIG, PKT_IDENT};
        for (int i = 0; i < 3; i++) begin
            next_pkt(i == 0 ? lim : 8, d, n);
            check("opening kind", k, order[i]);
            check("output early", out_en, 1'b0);
        end
        next_pkt(8, first_ce, n);
        check("first loop kind", k, PKT_CTRL_ERR);
        check("contract", link_a.contract, 1'b1);
        check("power on", power_on, 1'b1);
        n = 0;
        while (out_en !== 1'b1 && n < 3000) begin
            @(posedge core_clk_i);
            n++;
        end
        check("output on", out_en, 1'b1);
        check("ramp level", in_band(vrect, `STARTUP_TGT_MV), 1'b1);
    endtask : bring_up
    // ==========================================================
    // Scenarios
    task automatic test_presence();
        logic [15:0] lv[3];
        logic ex[3];
        lv = '{16'h0641, 16'h0640, 16'h063F};
        ex = '{1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 3; i++) begin
            pmem <= lv[i];
            repeat (3) @(posedge core_clk_i);
            check("presence", pd_wire, ex[i]);
        end
    endtask : test_presence
    task automatic test_startup();
        detect <= 1'b1;
        bring_up(100, d);
        check("ramp request", d, 8'h5D);
    endtask : test_startup
    task automatic test_targets();
        logic [15:0] cur[3];
        logic [15:0] tgt[3];
        cur = '{16'h0000, 16'h012C, 16'h03E8};
        tgt = '{`TGT_LIGHT_MV, `TGT_MID_MV, `TGT_HEAVY_MV};
        for (int i = 0; i < 3; i++) begin
            iout <= cur[i];
            repeat (CONV) @(posedge core_clk_i);
            check("target", in_band(vrect, tgt[i]), 1'b1);
            check("no early end", link_a.contract, 1'b1);
        end
        next_pkt(SLOW + 10, d, n);
        next_pkt(SLOW + 10, d, n);
        check("slow period", n >= SLOW - 2 && n <= SLOW + 2, 1'b1);
    endtask : test_targets
    task automatic test_overvoltage();
        int t0;
        t0 = cycles;
        hold_mv <= 16'h30D4;
        hold_en <= 1'b1;
        next_pkt(FAST + 5, d, n);
        check("lower request", d, `CE_MAX_DOWN);
        repeat (2) @(posedge core_clk_i);
        check("ldo off", ldo_en, 1'b0);
        check("output off", out_en, 1'b0);
        hold_mv <= 16'h2328;
        repeat (3) @(posedge core_clk_i);
        check("ldo on", ldo_en, 1'b1);
        next_pkt(FAST + 5, d, n);
        next_pkt(FAST + 5, d, n);
        check("fast period", n >= FAST - 2 && n <= FAST + 2, 1'b1);
        check("error value", d, 8'h83);
        // Host alignment aid forces a zero error while vrect is held above target but below the overvoltage limit
        align <= 1'b1;
        next_pkt(FAST + 5, d, n);
        next_pkt(FAST + 5, d, n);
        check("align value", d, 8'h00);
        align <= 1'b0;
        wait_end(FAST + 5);
        check("overvoltage end", d, `EPT_OVERVOLT);
        check("settle time", cycles - t0 >= CONV, 1'b1);
        hold_en <= 1'b0;
    endtask : test_overvoltage
    task automatic test_end_codes();
        logic [15:0] th[5];
        logic [7:0] code[5];
        th = '{16'h0320, 16'h0096, 16'h0032, 16'h05DC, 16'h0320};
        code = '{`EPT_FAULT, `EPT_OVERTEMP, `EPT_OVERTEMP, `EPT_CHARGED, `EPT_UNKNOWN};
        for (int i = 0; i < 5; i++) begin
            bring_up(GAP + 50, d);
            fault <= (i == 0);
            adapter <= (i == 4);
            therm <= th[i];
            wait_end(SLOW + 10);
            check("end sent", d, code[i]);
            repeat (4) @(posedge core_clk_i);
            check("end taken", end_reason, code[i]);
            check("end latched", ept_code, code[i]);
            check("power off", power_on, 1'b0);
            check("contract off", link_a.contract, 1'b0);
            check("output off", out_en, 1'b0);
            if (i == 3) begin
                check("low power", low_power, 1'b1);
            end
            next_pkt(GAP + 50, d, n);
            check("startup end", k, PKT_END);
            fault <= 1'b0;
            adapter <= 1'b0;
            therm <= 16'h0320;
        end
    endtask : test_end_codes
    initial begin
        rst_i = 1'b1;
        adapter = 1'b0;
        fault = 1'b0;
        align = 1'b0;
        detect = 1'b0;
        hold_en = 1'b0;
        hold_mv = 16'h0000;
        iout = 16'h0000;
        ilim = 16'h03E8;
        therm = 16'h0320;
        pmem = 16'h0000;
        repeat (8) @(posedge core_clk_i);
        check("ldo reset", ldo_en, 1'b1);
        check("output reset", out_en, 1'b0);
        rst_i <= 1'b0;
        test_presence();
        test_startup();
        test_targets();
        test_overvoltage();
        test_end_codes();
        results();
    end
endmodule : testbench
`default_nettype wire
